/* File: core/fcls_first_order.sv */
// First-order lag on the motor-to-scale position difference
`timescale 1ns/100ps
module fcls_first_order #(
   parameter int W = 32
) (
   input wire logic refClk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic [3:0] shift,
   input wire logic signed [W-1:0] din,
   output logic signed [W-1:0] dout
);

   logic signed [W:0] err;

   assign err = {din[W-1], din} - {dout[W-1], dout};

   // ------------------------------------------------------------
   // Lag update on each tick
   // ------------------------------------------------------------
   always_ff @(posedge refClk or negedge rstn) begin
      if (!rstn) begin
         dout <= '0;
      end else if (tick) begin
         dout <= dout + W'(err >>> shift);
      end
   end

endmodule : fcls_first_order

/* File: core/fcls_overrun_detect.sv */
// Position-gap and velocity-gap overrun comparison
`timescale 1ns/100ps
module fcls_overrun_detect (
   input wire logic refClk,
   input wire logic rstn,
   input wire fcls_pkg::fcls_fb_t fb,
   input wire logic velMode,
   input wire logic [31:0] widthUm,
   input wire logic [31:0] maxSpeed,
   output logic overrun,
   output logic [31:0] gap
);

   logic signed [32:0] posDiff;
   logic signed [32:0] velDiff;
   logic [32:0] posAbs;
   logic [32:0] velAbs;
   logic [39:0] velScaled;
   logic [39:0] speedLimit;

   assign posDiff = {fb.motorPos[31], fb.motorPos}
      - {fb.scalePos[31], fb.scalePos};
   assign velDiff = {fb.motorVel[31], fb.motorVel}
      - {fb.scaleVel[31], fb.scaleVel};
   assign posAbs = posDiff[32] ? 33'(-posDiff) : 33'(posDiff);
   assign velAbs = velDiff[32] ? 33'(-velDiff) : 33'(velDiff);
   assign velScaled = 40'(velAbs) * 40'(fcls_pkg::PCT_FULL);
   assign speedLimit = 40'(maxSpeed) * 40'(fcls_pkg::SPEED_PCT);

   // ------------------------------------------------------------
   // Comparison
   // ------------------------------------------------------------
   always_ff @(posedge refClk or negedge rstn) begin
      if (!rstn) begin
         overrun <= 1'b0;
         gap <= '0;
      end else begin
         gap <= posAbs[32] ? 32'hFFFF_FFFF : posAbs[31:0];
         if (velMode) begin
            overrun <= velScaled > speedLimit; // RULE2
         end else begin
            overrun <= posAbs > 33'(widthUm); // RULE1
         end
      end
   end

endmodule : fcls_overrun_detect

/* File: core/fcls_pkg.sv */
// Shared constants, types and register map of the full-closed-loop supervisor
package fcls_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] REG_SVF1 = 8'h00;
   localparam logic [7:0] REG_SVF5 = 8'h04;
   localparam logic [7:0] REG_OVR_WIDTH = 8'h08;
   localparam logic [7:0] REG_DELAY_AMT = 8'h0C;
   localparam logic [7:0] REG_TORQUE_OFS = 8'h10;
   localparam logic [7:0] REG_MEC_GAIN = 8'h14;
   localparam logic [7:0] REG_DUAL_FB = 8'h18;
   localparam logic [7:0] REG_MAX_SPEED = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_MASK = 8'h24;
   localparam logic [7:0] REG_ALARM = 8'h28;
   localparam logic [7:0] REG_GAP = 8'h2C;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SVF1_DELAY_LSB = 0;
   localparam int SVF5_INC_BIT = 2;
   localparam int SVF5_UM_BIT = 13;
   localparam int DUAL_EN_BIT = 0;
   localparam int DUAL_SHIFT_LSB = 4;
   localparam int ST_OVERRUN_BIT = 0;
   localparam int ST_BADSET_BIT = 1;
   localparam int ALARM_CLR_BIT = 0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_DUAL_FB = 32'h0000_0040;
   localparam logic [31:0] RST_MAX_SPEED = 32'h0000_FFFF;

   // ------------------------------------------------------------
   // Ranges, scales and codes
   // ------------------------------------------------------------
   localparam logic [7:0] ALARM_OVERRUN = 8'h2B;
   localparam logic [7:0] ALARM_NONE = 8'h00;
   localparam int OVR_MIN = -1;
   localparam int OVR_MAX = 32767;
   localparam int DELAY_MAX = 32767;
   localparam int TRQ_PCT_MAX = 100;
   localparam int PCT_FINE = 100;
   localparam int MEC_MAX = 30000;
   localparam int MEC_SCALE = 1000;
   localparam int DEFAULT_WIDTH_MM = 2;
   localparam int UM_PER_MM = 1000;
   localparam int SPEED_PCT = 30;
   localparam int PCT_FULL = 100;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int FILTER_TICK_NS = 1000;
   localparam int FILTER_TICK_CYC = (FILTER_TICK_NS + CLK_NS - 1) / CLK_NS;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {DLY_OFF, DLY_TYPE1, DLY_TYPE2, DLY_BAD}
      fcls_delay_t;

   typedef struct packed {
      logic signed [31:0] motorPos;
      logic signed [31:0] scalePos;
      logic signed [31:0] motorVel;
      logic signed [31:0] scaleVel;
   } fcls_fb_t;

   typedef struct packed {
      logic signed [31:0] cmdPos;
      logic signed [31:0] accelCmd;
      logic signed [31:0] posDroop;
   } fcls_cmd_t;

endpackage : fcls_pkg

/* File: core/fcls_top.sv */
// Full-closed-loop supervision, compensation and register slave
`timescale 1ns/100ps

// How it works
// RULE1: Compare motor encoder and scale; gap above width raises overrun alarm 43.
// RULE2: Width -1 selects velocity-gap test at 30 percent of max motor speed.
// RULE3: Width zero uses a fixed two millimetre detection width.
// RULE4: Width range -1 to 32767, millimetres or micrometres by function-five bit D.
// RULE5: An overrun stops the axis.
// RULE6: Delay type field: 00 off, 01 type 1, 10 type 2, 11 prohibited.
// RULE7: Type 2 applies lead reduction only once position droop is zero.
// RULE8: Delay compensation amount accepted from 0 to 32767.
// RULE9: Torque offset sign gives pull-up direction; zero means no pull-up.
// RULE10: Torque offset range -100 to 100 percent of stall current.
// RULE11: Increment bit 2 selects percent or 0.01 percent units.
// RULE12: Machine-end compensation shifts target by commanded acceleration times gain.
// RULE13: Machine-end gain -30000 to 30000 in 0.1 percent steps; zero unused.
// RULE14: Dual feedback blends motor and scale through a first-order lag.
// RULE15: Overrun alarm latches and holds the stop until software clears it.
module fcls_top #(
   parameter int FILTER_TICKS = fcls_pkg::FILTER_TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire fcls_pkg::fcls_fb_t fb,
   input wire fcls_pkg::fcls_cmd_t cmd,
   output logic signed [31:0] motorTarget,
   output logic signed [31:0] fbPos,
   output logic signed [31:0] torqueOffset,
   output logic pullUpEn,
   output logic pullUpNeg,
   output logic [14:0] leadReduce,
   output logic axisStop,
   output logic [7:0] alarmCode,
   output logic irq
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] laneMerge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         r[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : r[i*8 +: 8];
      end
      return r;
   endfunction : laneMerge

   function automatic logic [31:0] clampS(
      input logic [31:0] v,
      input int lo,
      input int hi
   );
      logic signed [31:0] s;
      s = signed'(v);
      return (s < lo) ? 32'(lo) : (s > hi) ? 32'(hi) : v;
   endfunction : clampS

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] servoFunctionOne;
   logic [31:0] servoFunctionFive;
   logic [31:0] overrunWidth;
   logic [31:0] speedDelayCompAmount;
   logic [31:0] torqueOffsetValue;
   logic [31:0] machineEndCompGain;
   logic [31:0] dualFb;
   logic [31:0] maxSpeed;
   logic [1:0] status;
   logic [1:0] mask;
   logic alarmLatched;

   logic wbReq;
   logic wbWr;
   logic [31:0] wdMerged;
   logic [31:0] next_rdata;
   logic [31:0] gap;
   logic overrunHit;
   logic badSetEvt;
   logic alarmClr;
   logic incFine;
   logic fbTick;
   logic [15:0] tickCnt;
   logic signed [31:0] fbLag;
   logic signed [31:0] fbDiff;
   logic [31:0] widthUm;
   logic velMode;
   fcls_pkg::fcls_delay_t delayType;
   logic signed [47:0] mecProd;
   logic signed [47:0] mecShift;
   int trqMax;

   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbWr = wbReq && wb_we_i;
   assign incFine = servoFunctionFive[fcls_pkg::SVF5_INC_BIT];
   assign trqMax = incFine ? fcls_pkg::TRQ_PCT_MAX * fcls_pkg::PCT_FINE
      : fcls_pkg::TRQ_PCT_MAX; // RULE11
   assign alarmClr = wbWr && wb_adr_i == fcls_pkg::REG_ALARM
      && wb_sel_i[0] && wb_dat_i[fcls_pkg::ALARM_CLR_BIT];

   assign wdMerged = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);

   // ------------------------------------------------------------
   // Bus slave: one-cycle ack, zero for unmapped reads
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wbReq;
         if (wbReq && !wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   always_comb begin
      unique case (wb_adr_i)
         fcls_pkg::REG_SVF1: next_rdata = servoFunctionOne;
         fcls_pkg::REG_SVF5: next_rdata = servoFunctionFive;
         fcls_pkg::REG_OVR_WIDTH: next_rdata = overrunWidth;
         fcls_pkg::REG_DELAY_AMT: next_rdata = speedDelayCompAmount;
         fcls_pkg::REG_TORQUE_OFS: next_rdata = torqueOffsetValue;
         fcls_pkg::REG_MEC_GAIN: next_rdata = machineEndCompGain;
         fcls_pkg::REG_DUAL_FB: next_rdata = dualFb;
         fcls_pkg::REG_MAX_SPEED: next_rdata = maxSpeed;
         fcls_pkg::REG_STATUS: next_rdata = {30'h0, status};
         fcls_pkg::REG_MASK: next_rdata = {30'h0, mask};
         fcls_pkg::REG_ALARM: next_rdata = {23'h0, alarmLatched, alarmCode};
         fcls_pkg::REG_GAP: next_rdata = gap;
         default: next_rdata = '0;
      endcase
   end

   // ------------------------------------------------------------
   // Configuration writes with range saturation
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         servoFunctionOne <= fcls_pkg::RST_ZERO;
         servoFunctionFive <= fcls_pkg::RST_ZERO;
         overrunWidth <= fcls_pkg::RST_ZERO;
         speedDelayCompAmount <= fcls_pkg::RST_ZERO;
         torqueOffsetValue <= fcls_pkg::RST_ZERO;
         machineEndCompGain <= fcls_pkg::RST_ZERO;
         dualFb <= fcls_pkg::RST_DUAL_FB;
         maxSpeed <= fcls_pkg::RST_MAX_SPEED;
         mask <= '0;
      end else if (wbWr) begin
         unique case (wb_adr_i)
            fcls_pkg::REG_SVF1:
               servoFunctionOne <= laneMerge(servoFunctionOne, wb_dat_i,
                  wb_sel_i);
            fcls_pkg::REG_SVF5:
               servoFunctionFive <= laneMerge(servoFunctionFive, wb_dat_i,
                  wb_sel_i);
            fcls_pkg::REG_OVR_WIDTH:
               overrunWidth <= clampS(wdMerged, fcls_pkg::OVR_MIN,
                  fcls_pkg::OVR_MAX); // RULE4
            fcls_pkg::REG_DELAY_AMT:
               speedDelayCompAmount <= clampS(wdMerged, 0,
                  fcls_pkg::DELAY_MAX); // RULE8
            fcls_pkg::REG_TORQUE_OFS:
               torqueOffsetValue <= clampS(wdMerged, -trqMax,
                  trqMax); // RULE10
            fcls_pkg::REG_MEC_GAIN:
               machineEndCompGain <= clampS(wdMerged, -fcls_pkg::MEC_MAX,
                  fcls_pkg::MEC_MAX); // RULE13
            fcls_pkg::REG_DUAL_FB:
               dualFb <= laneMerge(dualFb, wb_dat_i, wb_sel_i);
            fcls_pkg::REG_MAX_SPEED:
               maxSpeed <= laneMerge(maxSpeed, wb_dat_i, wb_sel_i);
            fcls_pkg::REG_MASK:
               mask <= wdMerged[1:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Delay compensation type
   // ------------------------------------------------------------
   assign delayType = fcls_pkg::fcls_delay_t'(
      servoFunctionOne[fcls_pkg::SVF1_DELAY_LSB +: 2]); // RULE6
   assign badSetEvt = delayType == fcls_pkg::DLY_BAD; // RULE6

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         leadReduce <= '0;
      end else begin
         unique case (delayType)
            fcls_pkg::DLY_OFF, fcls_pkg::DLY_BAD: leadReduce <= '0; // RULE6
            fcls_pkg::DLY_TYPE1: leadReduce <= speedDelayCompAmount[14:0];
            fcls_pkg::DLY_TYPE2:
               leadReduce <= (cmd.posDroop == 0) ?
                  speedDelayCompAmount[14:0] : 15'h0000; // RULE7
         endcase
      end
   end

   // ------------------------------------------------------------
   // Torque offset and pull-up direction
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         torqueOffset <= '0;
         pullUpEn <= 1'b0;
         pullUpNeg <= 1'b0;
      end else begin
         torqueOffset <= incFine ? signed'(torqueOffsetValue)
            : 32'(signed'(torqueOffsetValue) * fcls_pkg::PCT_FINE); // RULE11
         pullUpEn <= torqueOffsetValue != 0; // RULE9
         pullUpNeg <= torqueOffsetValue[31]; // RULE9
      end
   end

   // ------------------------------------------------------------
   // Machine-end compensation of the motor target
   // ------------------------------------------------------------
   assign mecProd = 48'(cmd.accelCmd) * 48'(signed'(machineEndCompGain));
   assign mecShift = mecProd / 48'(fcls_pkg::MEC_SCALE);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         motorTarget <= '0;
      end else if (machineEndCompGain == 0) begin
         motorTarget <= cmd.cmdPos; // RULE13
      end else begin
         motorTarget <= cmd.cmdPos + mecShift[31:0]; // RULE12
      end
   end

   // ------------------------------------------------------------
   // Dual feedback blending
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt <= '0;
         fbTick <= 1'b0;
      end else if (tickCnt == 16'(FILTER_TICKS - 1)) begin
         tickCnt <= '0;
         fbTick <= 1'b1;
      end else begin
         tickCnt <= tickCnt + 16'h0001;
         fbTick <= 1'b0;
      end
   end

   assign fbDiff = fb.motorPos - fb.scalePos;

   fcls_first_order #(
      .W(32)
   ) uLag (
      .refClk(ref_clk),
      .rstn(rstn),
      .tick(fbTick),
      .shift(dualFb[fcls_pkg::DUAL_SHIFT_LSB +: 4]),
      .din(fbDiff),
      .dout(fbLag)
   );

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fbPos <= '0;
      end else if (dualFb[fcls_pkg::DUAL_EN_BIT]) begin
         fbPos <= fb.motorPos - fbLag; // RULE14
      end else begin
         fbPos <= fb.scalePos;
      end
   end

   // ------------------------------------------------------------
   // Overrun detection
   // ------------------------------------------------------------
   assign velMode = signed'(overrunWidth) == fcls_pkg::OVR_MIN; // RULE2

   always_comb begin
      if (overrunWidth == 0) begin // RULE3
         widthUm = 32'(fcls_pkg::DEFAULT_WIDTH_MM * fcls_pkg::UM_PER_MM);
      end else if (servoFunctionFive[fcls_pkg::SVF5_UM_BIT]) begin
         widthUm = overrunWidth; // RULE4
      end else begin
         widthUm = 32'(overrunWidth * fcls_pkg::UM_PER_MM);
      end
   end

   fcls_overrun_detect uOvr (
      .refClk(ref_clk),
      .rstn(rstn),
      .fb(fb),
      .velMode(velMode),
      .widthUm(widthUm),
      .maxSpeed(maxSpeed),
      .overrun(overrunHit),
      .gap(gap)
   );

   // ------------------------------------------------------------
   // Alarm latch and axis stop
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         alarmLatched <= 1'b0;
      end else if (overrunHit) begin
         alarmLatched <= 1'b1; // RULE15
      end else if (alarmClr) begin
         alarmLatched <= 1'b0; // RULE15
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         axisStop <= 1'b0;
         alarmCode <= fcls_pkg::ALARM_NONE;
      end else begin
         axisStop <= alarmLatched || overrunHit; // RULE5
         alarmCode <= (alarmLatched || overrunHit) ?
            fcls_pkg::ALARM_OVERRUN : fcls_pkg::ALARM_NONE; // RULE1
      end
   end

   // ------------------------------------------------------------
   // Interrupt status, mask and output
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gStatus
         logic evt;
         logic clr;
         assign evt = (g == fcls_pkg::ST_OVERRUN_BIT) ? overrunHit
            : badSetEvt;
         assign clr = wbWr && wb_adr_i == fcls_pkg::REG_STATUS
            && wb_sel_i[0] && wb_dat_i[g];
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               status[g] <= 1'b0;
            end else if (evt) begin
               status[g] <= 1'b1;
            end else if (clr) begin
               status[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

endmodule : fcls_top

/* File: verif/fcls_monitor.sv */
// Port assertions for the full-closed-loop supervisor
`timescale 1ns/100ps
module fcls_monitor (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire fcls_pkg::fcls_cmd_t cmd,
   input wire logic signed [31:0] motorTarget,
   input wire logic signed [31:0] torqueOffset,
   input wire logic pullUpEn,
   input wire logic pullUpNeg,
   input wire logic axisStop,
   input wire logic [7:0] alarmCode
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [3:0] clrAge;
   // Cycles since software last cleared the alarm latch
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         clrAge <= 4'hF;
      end else if (wb_cyc_i && wb_we_i && wb_dat_i[0]
            && wb_adr_i == fcls_pkg::REG_ALARM) begin
         clrAge <= 4'h0;
      end else if (clrAge != 4'hF) begin
         clrAge <= clrAge + 4'h1;
      end
   end
   sequence busReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ackPulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_ONE: assert property (busReq |=> ackPulse)
      else $error("no single ack after request");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
      else $error("ack without request");
   AST_STOP_CODE: assert property (
      alarmCode == (axisStop ? 8'h2B : 8'h00))
      else $error("alarm code disagrees with stop");
   AST_STOP_HOLD: assert property (
      $fell(axisStop) |-> clrAge < 4'h4)
      else $error("stop released without clear");
   AST_PULL_EN: assert property (pullUpEn == (torqueOffset != 0))
      else $error("pull-up enable wrong");
   AST_PULL_NEG: assert property (pullUpNeg == (torqueOffset < 0))
      else $error("pull-up direction wrong");
   AST_TORQUE_RANGE: assert property (
      torqueOffset >= -10000 && torqueOffset <= 10000)
      else $error("torque offset out of range");
   AST_TARGET_FLAT: assert property (
      $past(cmd.accelCmd) == 0 |-> motorTarget == $past(cmd.cmdPos))
      else $error("target shifted without acceleration");
endmodule : fcls_monitor

bind fcls_top fcls_monitor u_fcls_monitor (.ref_clk(ref_clk),
   .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .cmd(cmd), .motorTarget(motorTarget),
   .torqueOffset(torqueOffset), .pullUpEn(pullUpEn),
   .pullUpNeg(pullUpNeg), .axisStop(axisStop), .alarmCode(alarmCode));

/* File: verif/fcls_plant_model.sv */
// Encoder, scale and controller model feeding the supervisor
`timescale 1ns/100ps
module fcls_plant_model (
   input wire logic ref_clk,
   input wire fcls_pkg::fcls_fb_t fbSet,
   input wire fcls_pkg::fcls_cmd_t cmdSet,
   output fcls_pkg::fcls_fb_t fb,
   output fcls_pkg::fcls_cmd_t cmd
);
   initial begin
      fb = '0;
      cmd = '0;
   end
   // Readings update just after an edge, as sampled sensors do
   always @(posedge ref_clk) begin
      fb <= fbSet;
      cmd <= cmdSet;
   end
endmodule : fcls_plant_model

/* File: verif/fcls_top_test.sv */
// Self-checking bench for the full-closed-loop supervisor
`timescale 1ns/100ps
module fcls_top_test;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDat = 32'h0;
   logic [31:0] wbDatO, q;
   logic wbAck, pullUpEn, pullUpNeg, axisStop, irq;
   fcls_pkg::fcls_fb_t fbSet = '0;
   fcls_pkg::fcls_cmd_t cmdSet = '0;
   fcls_pkg::fcls_fb_t fb;
   fcls_pkg::fcls_cmd_t cmd;
   logic signed [31:0] motorTarget, fbPos, torqueOffset;
   logic [14:0] leadReduce;
   logic [7:0] alarmCode;
   int fails = 0;
   int checkCount = 0;
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   fcls_plant_model u_fcls_plant_model (.ref_clk(ref_clk), .fbSet(fbSet),
      .cmdSet(cmdSet), .fb(fb), .cmd(cmd));
   fcls_top #(.FILTER_TICKS(2)) u_fcls_top (.ref_clk(ref_clk), .rstn(rstn),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDat), .wb_sel_i(4'hF), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .fb(fb), .cmd(cmd), .motorTarget(motorTarget), .fbPos(fbPos),
      .torqueOffset(torqueOffset), .pullUpEn(pullUpEn), .pullUpNeg(pullUpNeg),
      .leadReduce(leadReduce), .axisStop(axisStop), .alarmCode(alarmCode),
      .irq(irq));
   task automatic print_verdict;
      $display("checks %0d fails %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic signed [31:0] got, input int lo,
         input int hi);
      checkCount++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         fails++;
         $display("unexpected at %0t: got %0d want %0d", $time, got, lo);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDat <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatO;
      if (n >= 20) begin
         fails++;
         $display("unexpected at %0t: no bus answer", $time);
      end
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input int e);
      bus(1'b0, a, 32'h0);
      chk(q, e, e);
   endtask : rd
   task automatic stopAt(input int pos, input int vel, input int e);
      @(posedge ref_clk);
      fbSet.motorPos <= pos;
      fbSet.motorVel <= vel;
      repeat (5) @(posedge ref_clk);
      chk(axisStop, e, e);
   endtask : stopAt
   task automatic clrAlarm;
      stopAt(0, 0, 1);
      wr(fcls_pkg::REG_ALARM, 32'h1);
      wr(fcls_pkg::REG_STATUS, 32'h3);
      repeat (3) @(posedge ref_clk);
      chk(axisStop, 0, 0);
      chk(alarmCode, 0, 0);
   endtask : clrAlarm
   task automatic tRegs;
      rd(fcls_pkg::REG_DUAL_FB, 64);
      rd(fcls_pkg::REG_MAX_SPEED, 65535);
      rd(8'h30, 0);
      wr(fcls_pkg::REG_OVR_WIDTH, 32'hFFFF_FFF9);
      rd(fcls_pkg::REG_OVR_WIDTH, -1);
      wr(fcls_pkg::REG_DELAY_AMT, 32'h0000_9C40);
      rd(fcls_pkg::REG_DELAY_AMT, 32767);
      wr(fcls_pkg::REG_MEC_GAIN, 32'hFFFF_63C0);
      rd(fcls_pkg::REG_MEC_GAIN, -30000);
   endtask : tRegs
   task automatic tDual;
      wr(fcls_pkg::REG_OVR_WIDTH, 32'h0000_7FFF);
      wr(fcls_pkg::REG_DUAL_FB, 32'h0000_0041);
      fbSet.motorPos <= 1000;
      repeat (3) @(posedge ref_clk);
      chk(fbPos, 850, 1000);
      repeat (400) @(posedge ref_clk);
      chk(fbPos, 0, 15);
      wr(fcls_pkg::REG_DUAL_FB, 32'h0);
      fbSet.scalePos <= 7;
      repeat (3) @(posedge ref_clk);
      chk(fbPos, 7, 7);
      fbSet <= '0;
   endtask : tDual
   task automatic tOverrun;
      wr(fcls_pkg::REG_OVR_WIDTH, 32'h0);
      wr(fcls_pkg::REG_MASK, 32'h1);
      stopAt(2000, 0, 0);
      stopAt(2001, 0, 1);
      chk(alarmCode, 43, 43);
      chk(irq, 1, 1);
      rd(fcls_pkg::REG_GAP, 2001);
      clrAlarm();
      chk(irq, 0, 0);
      wr(fcls_pkg::REG_MASK, 32'h0);
      wr(fcls_pkg::REG_SVF5, 32'h0000_2000);
      wr(fcls_pkg::REG_OVR_WIDTH, 32'h3);
      stopAt(3, 0, 0);
      stopAt(4, 0, 1);
      chk(irq, 0, 0);
      clrAlarm();
      wr(fcls_pkg::REG_OVR_WIDTH, 32'hFFFF_FFFF);
      wr(fcls_pkg::REG_MAX_SPEED, 32'h0000_03E8);
      stopAt(0, 300, 0);
      stopAt(0, 301, 1);
      clrAlarm();
   endtask : tOverrun
   task automatic tDelay;
      wr(fcls_pkg::REG_DELAY_AMT, 32'h0000_02BC);
      cmdSet.posDroop <= 5;
      for (int t = 0; t < 4; t++) begin
         wr(fcls_pkg::REG_SVF1, 32'(t));
         repeat (3) @(posedge ref_clk);
         chk(leadReduce, t == 1 ? 700 : 0, t == 1 ? 700 : 0);
      end
      rd(fcls_pkg::REG_STATUS, 2);
      wr(fcls_pkg::REG_SVF1, 32'h2);
      cmdSet.posDroop <= 0;
      repeat (4) @(posedge ref_clk);
      chk(leadReduce, 700, 700);
      wr(fcls_pkg::REG_STATUS, 32'h2);
   endtask : tDelay
   task automatic torq(input logic [31:0] v, input int e, input int en);
      wr(fcls_pkg::REG_TORQUE_OFS, v);
      repeat (3) @(posedge ref_clk);
      chk(torqueOffset, e, e);
      chk(pullUpEn, en, en);
   endtask : torq
   task automatic tTorque;
      torq(32'h0000_0096, 10000, 1);
      torq(32'h5, 500, 1);
      torq(32'hFFFF_FFFD, -300, 1);
      chk(pullUpNeg, 1, 1);
      torq(32'h0, 0, 0);
      wr(fcls_pkg::REG_SVF5, 32'h4);
      torq(32'h0000_00FA, 250, 1);
   endtask : tTorque
   task automatic target(input int acc, input int e);
      cmdSet.cmdPos <= 100;
      cmdSet.accelCmd <= acc;
      repeat (3) @(posedge ref_clk);
      chk(motorTarget, e, e);
   endtask : target
   task automatic tMachineEnd;
      wr(fcls_pkg::REG_MEC_GAIN, 32'h0000_01F4);
      target(2000, 1100);
      target(-3, 99);
      wr(fcls_pkg::REG_MEC_GAIN, 32'h0);
      target(2000, 100);
   endtask : tMachineEnd
   initial begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      tRegs();
      tDual();
      tOverrun();
      tDelay();
      tTorque();
      tMachineEnd();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule : fcls_top_test
